// ### hdl/rsf_map.vh
// Purpose: register map, field positions, reset values and timing of the
//          reset source flag block
// Assumes: 8-bit register port, 250 MHz system clock
// Notes:   definitions only
`ifndef RSF_MAP_VH
`define RSF_MAP_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define RSF_ADDR_CAUSE 8'hef
`define RSF_ADDR_STATUS 8'hf0
`define RSF_ADDR_MASK 8'hf1

// ----------------------------------------
// field positions, same layout in all three registers
// ----------------------------------------
`define RSF_BIT_PIN 0
`define RSF_BIT_PWR 1
`define RSF_BIT_CLK 2
`define RSF_BIT_WDT 3
`define RSF_BIT_SW 4
`define RSF_BIT_CMP 5
`define RSF_BIT_FLASH 6
`define RSF_NFLAG 7

// ----------------------------------------
// reset values
// ----------------------------------------
`define RSF_FLAGS_POR 7'h02
`define RSF_STATUS_RST 7'h00
`define RSF_MASK_RST 7'h00
`define RSF_SYNC_RST 4'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define RSF_CLK_PERIOD_NS 4
`define RSF_HOLD_NS 100
`define RSF_HOLD_CYC (((`RSF_HOLD_NS) + (`RSF_CLK_PERIOD_NS) - 1) / (`RSF_CLK_PERIOD_NS))

`endif

// ### hdl/rsf_sync2.v
// Purpose: two flip-flop synchroniser for asynchronous levels
// Assumes: synchronous active-low reset
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps

module rsf_sync2 #(
   parameter WIDTH = 4,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   // clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // levels
   input wire [WIDTH-1:0] d_i,
   output wire [WIDTH-1:0] q_o
);

   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] sync_ff;

   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= d_i;
         sync_ff <= meta_ff;
      end
   end

   assign q_o = sync_ff;

endmodule // rsf_sync2

// ### hdl/rsf_reset_flags.v
// Purpose: reset source enables and flags, system reset request and hold
// Assumes: RST_N_I is the power-on reset of this block; all other system
//          resets are requested by SYS_RESET_O and leave this block running
// Notes:   flags update once, when the hold of a system reset ends
//
// Contract
// - after a flash fault reset the flash flag reads 1; writes ignored
// - writing 1 to the comparator bit enables comparator 0 low as reset
// - comparator bit reads 1 if comparator 0 caused the last reset
// - writing 1 to the software bit starts a system reset at once
// - software bit reads 1 after a software forced reset
// - watchdog flag reads 1 after watchdog overflow reset; read-only
// - writing 1 to clock loss bit arms detector; armed detector resets
// - clock loss bit reads 1 after a clock loss reset
// - writing 1 to the power bit makes the supply monitor a source
// - power flag set after every power-on and supply monitor reset
// - while power flag is 1 other flags are undefined
// - pin flag reads 1 after an external pin reset; read-only
// - writing 0 to clock loss bit disables the detector
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "rsf_map.vh"

module rsf_reset_flags (
   // clock and reset
   input wire CLK_I,
   input wire RST_N_I,
   // register port
   input wire [7:0] ADDR_I,
   input wire [7:0] WDATA_I,
   input wire WR_I,
   input wire RD_I,
   output wire [7:0] RDATA_O,
   // asynchronous reset sources
   input wire RST_PIN_N_I,
   input wire CMP0_OUT_I,
   input wire SUPPLY_LOW_I,
   input wire CLK_MISSING_I,
   // synchronous reset sources
   input wire WDT_OVF_I,
   input wire FLASH_FAULT_I,
   // system reset and enables
   output wire SYS_RESET_O,
   output wire CMP_RST_EN_O,
   output wire CLK_LOSS_EN_O,
   output wire SUPPLY_RST_EN_O,
   // interrupt
   output wire IRQ_O
);

   // ----------------------------------------
   // constants
   // ----------------------------------------
   localparam ST_RUN = 1'b0;
   localparam ST_HOLD = 1'b1;
   localparam [31:0] HOLD_LAST = `RSF_HOLD_CYC - 1;
   localparam [7:0] HOLD_LOAD = HOLD_LAST[7:0];

   function addr_hit;
      input [7:0] addr;
      input [7:0] target;
      begin
         addr_hit = (addr == target);
      end
   endfunction

   // one cause only; pin first since it also stretches the hold
   function [`RSF_NFLAG-1:0] pick_cause;
      input [`RSF_NFLAG-1:0] req;
      begin
         pick_cause = {`RSF_NFLAG{1'b0}};
         if (req[`RSF_BIT_PIN]) begin
            pick_cause[`RSF_BIT_PIN] = 1'b1;
         end else if (req[`RSF_BIT_PWR]) begin
            pick_cause[`RSF_BIT_PWR] = 1'b1;
         end else if (req[`RSF_BIT_CLK]) begin
            pick_cause[`RSF_BIT_CLK] = 1'b1;
         end else if (req[`RSF_BIT_WDT]) begin
            pick_cause[`RSF_BIT_WDT] = 1'b1;
         end else if (req[`RSF_BIT_FLASH]) begin
            pick_cause[`RSF_BIT_FLASH] = 1'b1;
         end else if (req[`RSF_BIT_CMP]) begin
            pick_cause[`RSF_BIT_CMP] = 1'b1;
         end else if (req[`RSF_BIT_SW]) begin
            pick_cause[`RSF_BIT_SW] = 1'b1;
         end
      end
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg state_ff;
   reg [7:0] cnt_ff;
   reg [`RSF_NFLAG-1:0] cause_ff;
   reg [`RSF_NFLAG-1:0] flags_ff;
   reg cmp_en_ff;
   reg clk_en_ff;
   reg sup_en_ff;
   reg sys_rst_ff;
   reg [`RSF_NFLAG-1:0] status_ff;
   reg [`RSF_NFLAG-1:0] mask_ff;
   reg irq_ff;
   reg [7:0] rdata_ff;

   reg nxt_state;
   reg [7:0] nxt_cnt;
   reg [`RSF_NFLAG-1:0] nxt_cause;
   reg [`RSF_NFLAG-1:0] nxt_flags;
   reg nxt_cmp_en;
   reg nxt_clk_en;
   reg nxt_sup_en;
   reg [`RSF_NFLAG-1:0] stat_set;
   reg [`RSF_NFLAG-1:0] nxt_mask;
   reg [7:0] nxt_rdata;
   wire [`RSF_NFLAG-1:0] nxt_status;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   wire [3:0] sync_q;
   wire pin_n_s;
   wire cmp_s;
   wire sup_low_s;
   wire clk_miss_s;

   rsf_sync2 #(
      .WIDTH(4),
      .RST_VAL(`RSF_SYNC_RST)
   ) u_sync (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .d_i({CLK_MISSING_I, SUPPLY_LOW_I, CMP0_OUT_I, RST_PIN_N_I}),
      .q_o(sync_q)
   );

   assign pin_n_s = sync_q[0];
   assign cmp_s = sync_q[1];
   assign sup_low_s = sync_q[2];
   assign clk_miss_s = sync_q[3];

   // ----------------------------------------
   // bus decode and reset requests
   // ----------------------------------------
   wire in_run;
   wire wr_cause;
   wire wr_status;
   wire wr_mask;
   wire [`RSF_NFLAG-1:0] req;

   // the cpu is held in reset during the hold, so its writes are dropped
   assign in_run = (state_ff == ST_RUN);
   assign wr_cause = WR_I & in_run & addr_hit(ADDR_I, `RSF_ADDR_CAUSE);
   assign wr_status = WR_I & in_run & addr_hit(ADDR_I, `RSF_ADDR_STATUS);
   assign wr_mask = WR_I & in_run & addr_hit(ADDR_I, `RSF_ADDR_MASK);

   assign req[`RSF_BIT_PIN] = ~pin_n_s;
   assign req[`RSF_BIT_PWR] = sup_en_ff & sup_low_s;
   assign req[`RSF_BIT_CLK] = clk_en_ff & clk_miss_s;
   assign req[`RSF_BIT_WDT] = WDT_OVF_I;
   assign req[`RSF_BIT_SW] = wr_cause & WDATA_I[`RSF_BIT_SW];
   assign req[`RSF_BIT_CMP] = cmp_en_ff & ~cmp_s;
   assign req[`RSF_BIT_FLASH] = FLASH_FAULT_I;

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always @* begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_cause = cause_ff;
      nxt_flags = flags_ff;
      nxt_cmp_en = cmp_en_ff;
      nxt_clk_en = clk_en_ff;
      nxt_sup_en = sup_en_ff;
      stat_set = {`RSF_NFLAG{1'b0}};
      case (state_ff)
         ST_RUN: begin
            // flag bits are not stored by writes; only enables are
            if (wr_cause) begin
               nxt_cmp_en = WDATA_I[`RSF_BIT_CMP];
               nxt_clk_en = WDATA_I[`RSF_BIT_CLK];
               nxt_sup_en = WDATA_I[`RSF_BIT_PWR];
            end
            if (|req) begin
               // a system reset clears every source enable
               nxt_state = ST_HOLD;
               nxt_cnt = HOLD_LOAD;
               nxt_cause = pick_cause(req);
               nxt_cmp_en = 1'b0;
               nxt_clk_en = 1'b0;
               nxt_sup_en = 1'b0;
            end
         end
         ST_HOLD: begin
            if (cnt_ff != 8'h00) begin
               nxt_cnt = cnt_ff - 8'h01;
            end else if (pin_n_s) begin
               // pin held low stretches the hold
               nxt_state = ST_RUN;
               nxt_flags = cause_ff;
               stat_set = cause_ff;
            end
         end
         default: begin
            nxt_state = ST_RUN;
         end
      endcase
   end

   always @(posedge CLK_I) begin
      if (!RST_N_I) begin
         state_ff <= ST_RUN;
         cnt_ff <= 8'h00;
         cause_ff <= {`RSF_NFLAG{1'b0}};
         flags_ff <= `RSF_FLAGS_POR;
         cmp_en_ff <= 1'b0;
         clk_en_ff <= 1'b0;
         sup_en_ff <= 1'b0;
         sys_rst_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         cause_ff <= nxt_cause;
         flags_ff <= nxt_flags;
         cmp_en_ff <= nxt_cmp_en;
         clk_en_ff <= nxt_clk_en;
         sup_en_ff <= nxt_sup_en;
         sys_rst_ff <= (nxt_state == ST_HOLD);
      end
   end

   // ----------------------------------------
   // interrupt status, write one to clear
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `RSF_NFLAG; gi = gi + 1) begin : g_stat
         // a set in the clearing cycle wins
         assign nxt_status[gi] = stat_set[gi]
            | (status_ff[gi] & ~(wr_status & WDATA_I[gi]));
      end
   endgenerate

   always @* begin
      nxt_mask = mask_ff;
      if (wr_mask) begin
         nxt_mask = WDATA_I[`RSF_NFLAG-1:0];
      end
   end

   always @(posedge CLK_I) begin
      if (!RST_N_I) begin
         status_ff <= `RSF_STATUS_RST;
         mask_ff <= `RSF_MASK_RST;
         irq_ff <= 1'b0;
      end else begin
         status_ff <= nxt_status;
         mask_ff <= nxt_mask;
         irq_ff <= |(nxt_status & nxt_mask);
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always @* begin
      nxt_rdata = 8'h00;
      if (RD_I) begin
         if (addr_hit(ADDR_I, `RSF_ADDR_CAUSE)) begin
            // top bit unused, reads zero
            nxt_rdata = {1'b0, flags_ff};
         end else if (addr_hit(ADDR_I, `RSF_ADDR_STATUS)) begin
            nxt_rdata = {1'b0, status_ff};
         end else if (addr_hit(ADDR_I, `RSF_ADDR_MASK)) begin
            nxt_rdata = {1'b0, mask_ff};
         end
      end
   end

   always @(posedge CLK_I) begin
      if (!RST_N_I) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign RDATA_O = rdata_ff;
   assign SYS_RESET_O = sys_rst_ff;
   assign CMP_RST_EN_O = cmp_en_ff;
   assign CLK_LOSS_EN_O = clk_en_ff;
   assign SUPPLY_RST_EN_O = sup_en_ff;
   assign IRQ_O = irq_ff;

endmodule // rsf_reset_flags

// ### verif/rsf_reset_flags_monitor.sv
// Purpose: concurrent checks on the reset source flag block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the block at the foot of this file
`timescale 1ns/1ps
`include "rsf_map.vh"

module rsf_reset_flags_monitor (
   // clock and reset
   input logic CLK_I,
   input logic RST_N_I,
   // register port
   input logic [7:0] ADDR_I,
   input logic [7:0] WDATA_I,
   input logic WR_I,
   // sources
   input logic CMP0_OUT_I,
   input logic CLK_MISSING_I,
   input logic WDT_OVF_I,
   // outputs
   input logic SYS_RESET_O,
   input logic CMP_RST_EN_O,
   input logic CLK_LOSS_EN_O,
   input logic SUPPLY_RST_EN_O
);
   localparam int HC = `RSF_HOLD_CYC;
   logic [15:0] hold_cnt_ff;
   logic wr_cause;
   assign wr_cause = WR_I && ADDR_I == `RSF_ADDR_CAUSE && !SYS_RESET_O;
   // length of the current hold, so a short hold is caught
   always @(posedge CLK_I) begin
      hold_cnt_ff <= (RST_N_I && SYS_RESET_O) ? hold_cnt_ff + 16'h0001 : 16'h0000;
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   sequence s_en_wr;
      wr_cause && !WDATA_I[4];
   endsequence
   // sources pass a two-stage synchroniser, hence three cycles
   sequence s_cmp_low;
      (CMP_RST_EN_O && !CMP0_OUT_I && !SYS_RESET_O)[*3];
   endsequence
   sequence s_clk_gone;
      (CLK_LOSS_EN_O && CLK_MISSING_I && !SYS_RESET_O)[*3];
   endsequence
   AST_SW_FORCE: assert property (wr_cause && WDATA_I[4] |=> SYS_RESET_O)
      else $error("forced reset not started");
   AST_CMP_EN: assert property (s_en_wr |=> SYS_RESET_O || CMP_RST_EN_O == $past(WDATA_I[5]))
      else $error("comparator enable not stored");
   AST_CLK_EN: assert property (s_en_wr |=> SYS_RESET_O || CLK_LOSS_EN_O == $past(WDATA_I[2]))
      else $error("clock loss enable not stored");
   AST_SUP_EN: assert property (s_en_wr |=> SYS_RESET_O || SUPPLY_RST_EN_O == $past(WDATA_I[1]))
      else $error("supply enable not stored");
   AST_EN_CLR: assert property ($rose(SYS_RESET_O) |->
      !(CMP_RST_EN_O || CLK_LOSS_EN_O || SUPPLY_RST_EN_O))
      else $error("enables survive reset");
   AST_HOLD: assert property ($fell(SYS_RESET_O) |-> hold_cnt_ff >= HC)
      else $error("reset hold too short");
   AST_CMP_TRIG: assert property (s_cmp_low |-> ##[1:2] SYS_RESET_O)
      else $error("comparator reset missed");
   AST_CLK_TRIG: assert property (s_clk_gone |-> ##[1:2] SYS_RESET_O)
      else $error("clock loss reset missed");
   AST_WDT: assert property (WDT_OVF_I && !SYS_RESET_O |=> SYS_RESET_O)
      else $error("watchdog reset missed");
endmodule // rsf_reset_flags_monitor

bind rsf_reset_flags rsf_reset_flags_monitor i_mon (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
   .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .CMP0_OUT_I(CMP0_OUT_I),
   .CLK_MISSING_I(CLK_MISSING_I), .WDT_OVF_I(WDT_OVF_I), .SYS_RESET_O(SYS_RESET_O),
   .CMP_RST_EN_O(CMP_RST_EN_O), .CLK_LOSS_EN_O(CLK_LOSS_EN_O),
   .SUPPLY_RST_EN_O(SUPPLY_RST_EN_O));

// ### verif/rsf_reset_flags_tb.sv
// Purpose: self-checking bench for the reset source flag block
// Assumes: 250 MHz clock, register port with read data one cycle later
// Notes: every reset cause is raised once and read back
`timescale 1ns/1ps
`include "rsf_map.vh"

module rsf_reset_flags_tb;
   logic CLK_I = 1'b0;
   logic RST_N_I = 1'b0;
   logic [7:0] ADDR_I = 8'h00;
   logic [7:0] WDATA_I = 8'h00;
   logic WR_I = 1'b0, RD_I = 1'b0, RST_PIN_N_I = 1'b1, CMP0_OUT_I = 1'b1;
   logic SUPPLY_LOW_I = 1'b0, CLK_MISSING_I = 1'b0, WDT_OVF_I = 1'b0, FLASH_FAULT_I = 1'b0;
   logic [7:0] RDATA_O;
   logic SYS_RESET_O, CMP_RST_EN_O, CLK_LOSS_EN_O, SUPPLY_RST_EN_O, IRQ_O;
   int error_cnt = 0;
   int comparisons = 0;

   always #2 CLK_I = ~CLK_I;

   rsf_reset_flags i_rsf_reset_flags (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
      .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
      .RST_PIN_N_I(RST_PIN_N_I), .CMP0_OUT_I(CMP0_OUT_I), .SUPPLY_LOW_I(SUPPLY_LOW_I),
      .CLK_MISSING_I(CLK_MISSING_I), .WDT_OVF_I(WDT_OVF_I), .FLASH_FAULT_I(FLASH_FAULT_I),
      .SYS_RESET_O(SYS_RESET_O), .CMP_RST_EN_O(CMP_RST_EN_O), .CLK_LOSS_EN_O(CLK_LOSS_EN_O),
      .SUPPLY_RST_EN_O(SUPPLY_RST_EN_O), .IRQ_O(IRQ_O));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK_I);
      ADDR_I <= a;
      WDATA_I <= d;
      WR_I <= 1'b1;
      @(posedge CLK_I);
      WR_I <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge CLK_I);
      ADDR_I <= a;
      RD_I <= 1'b1;
      @(posedge CLK_I);
      RD_I <= 1'b0;
      #1 chk("read data", {24'h0, e}, {24'h0, RDATA_O});
   endtask

   // other flags are undefined while the power flag is set
   task automatic rchk_pwr();
      @(posedge CLK_I);
      ADDR_I <= `RSF_ADDR_CAUSE;
      RD_I <= 1'b1;
      @(posedge CLK_I);
      RD_I <= 1'b0;
      #1 chk("power flag", {24'h0, 8'h02}, {24'h0, RDATA_O & 8'h82});
      @(posedge CLK_I);
      #1 chk("read data idle", 32'h0, {24'h0, RDATA_O});
   endtask

   // waits out one system reset and checks its length
   task automatic hold();
      int n;
      n = 0;
      #1;
      while (SYS_RESET_O !== 1'b1 && n < 50) begin
         @(posedge CLK_I);
         #1 n++;
      end
      n = 0;
      while (SYS_RESET_O === 1'b1 && n < 200) begin
         @(posedge CLK_I);
         #1 n++;
      end
      chk("hold cycles", `RSF_HOLD_CYC, n);
      @(posedge CLK_I);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_por();
      rchk_pwr();
      rchk(`RSF_ADDR_STATUS, 8'h00);
      rchk(`RSF_ADDR_MASK, 8'h00);
      rchk(8'h55, 8'h00);
   endtask

   task automatic t_sw();
      wr(`RSF_ADDR_CAUSE, 8'h10);
      hold();
      rchk(`RSF_ADDR_CAUSE, 8'h10);
      rchk(`RSF_ADDR_STATUS, 8'h10);
      chk("irq masked", 1'b0, IRQ_O);
      wr(`RSF_ADDR_MASK, 8'h10);
      @(posedge CLK_I);
      #1 chk("irq raised", 1'b1, IRQ_O);
      wr(`RSF_ADDR_STATUS, 8'h10);
      @(posedge CLK_I);
      #1 chk("irq cleared", 1'b0, IRQ_O);
   endtask

   task automatic t_wdt();
      @(posedge CLK_I);
      WDT_OVF_I <= 1'b1;
      @(posedge CLK_I);
      WDT_OVF_I <= 1'b0;
      hold();
      rchk(`RSF_ADDR_CAUSE, 8'h08);
      // flag bits written high must neither reset nor change the flags
      wr(`RSF_ADDR_CAUSE, 8'h49);
      repeat (3) @(posedge CLK_I);
      #1 chk("no reset", 1'b0, SYS_RESET_O);
      rchk(`RSF_ADDR_CAUSE, 8'h08);
   endtask

   task automatic t_flash();
      @(posedge CLK_I);
      FLASH_FAULT_I <= 1'b1;
      @(posedge CLK_I);
      FLASH_FAULT_I <= 1'b0;
      hold();
      rchk(`RSF_ADDR_CAUSE, 8'h40);
   endtask

   task automatic t_pin();
      @(posedge CLK_I);
      RST_PIN_N_I <= 1'b0;
      @(posedge CLK_I);
      RST_PIN_N_I <= 1'b1;
      hold();
      rchk(`RSF_ADDR_CAUSE, 8'h01);
   endtask

   task automatic t_cmp();
      wr(`RSF_ADDR_CAUSE, 8'h20);
      #1 chk("cmp enable", 1'b1, CMP_RST_EN_O);
      @(posedge CLK_I);
      CMP0_OUT_I <= 1'b0;
      hold();
      CMP0_OUT_I <= 1'b1;
      rchk(`RSF_ADDR_CAUSE, 8'h20);
   endtask

   task automatic t_clk();
      wr(`RSF_ADDR_CAUSE, 8'h04);
      #1 chk("clk enable", 1'b1, CLK_LOSS_EN_O);
      wr(`RSF_ADDR_CAUSE, 8'h00);
      #1 chk("clk disable", 1'b0, CLK_LOSS_EN_O);
      @(posedge CLK_I);
      CLK_MISSING_I <= 1'b1;
      repeat (5) @(posedge CLK_I);
      #1 chk("disarmed", 1'b0, SYS_RESET_O);
      // drop the loss first so the armed detector sees a fresh timeout
      @(posedge CLK_I);
      CLK_MISSING_I <= 1'b0;
      repeat (2) @(posedge CLK_I);
      wr(`RSF_ADDR_CAUSE, 8'h04);
      CLK_MISSING_I <= 1'b1;
      hold();
      CLK_MISSING_I <= 1'b0;
      rchk(`RSF_ADDR_CAUSE, 8'h04);
   endtask

   task automatic t_sup();
      wr(`RSF_ADDR_CAUSE, 8'h02);
      #1 chk("supply enable", 1'b1, SUPPLY_RST_EN_O);
      @(posedge CLK_I);
      SUPPLY_LOW_I <= 1'b1;
      hold();
      SUPPLY_LOW_I <= 1'b0;
      rchk_pwr();
   endtask

   initial begin
      #20000;
      error_cnt++;
      end_of_test();
   end

   initial begin
      repeat (3) @(posedge CLK_I);
      RST_N_I <= 1'b1;
      t_por();
      t_sw();
      t_wdt();
      t_flash();
      t_pin();
      t_cmp();
      t_clk();
      t_sup();
      end_of_test();
   end
endmodule // rsf_reset_flags_tb
